//--- shared/scc_consts.svh
// constants of the sensor command checker: codes, offsets, fields, timing
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH
`define SCC_E_OK 10'h000
`define SCC_E104 10'h068
`define SCC_E200 10'h0c8
`define SCC_E202 10'h0ca
`define SCC_E204 10'h0cc
`define SCC_E210 10'h0d2
`define SCC_E214 10'h0d6
`define SCC_E220 10'h0dc
`define SCC_E232 10'h0e8
`define SCC_E234 10'h0ea
`define SCC_E236 10'h0ec
`define SCC_E262 10'h106
`define SCC_E320 10'h140
`define SCC_E321 10'h141
`define SCC_E322 10'h142
`define SCC_E323 10'h143
`define SCC_E360 10'h168
`define SCC_E361 10'h169
`define SCC_E362 10'h16a
`define SCC_E363 10'h16b
`define SCC_E364 10'h16c
`define SCC_E600 10'h258
`define SCC_E602 10'h25a
`define SCC_E616 10'h268
`define SCC_W320 10'h140
`define SCC_W570 10'h23a
`define SCC_MAX_LEN 9'h0ff
`define SCC_CHR_LO 8'h20
`define SCC_CHR_HI 8'h7e
`define SCC_CHR_CR 8'h0d
`define SCC_CHR_LF 8'h0a
`define SCC_CHR_SP 8'h20
`define SCC_SETUPS 8
`define SCC_REG_CTRL 3'h0
`define SCC_REG_STAT 3'h1
`define SCC_REG_SSEL 3'h2
`define SCC_REG_SDAT 3'h3
`define SCC_REG_SVLD 3'h4
`define SCC_CTRL_RST 16'h0000
`define SCC_CTRL_LASER 0
`define SCC_CTRL_MFI_LO 1
`define SCC_CTRL_MFI_HI 2
`define SCC_CTRL_MFI_LVL 3
`define SCC_CTRL_KEY_LO 4
`define SCC_CTRL_KEY_HI 5
`define SCC_CTRL_EXPERT 6
`define SCC_CTRL_TRIG_SW 7
`define SCC_CLK_HZ 25000000
`define SCC_MASTER_WAIT_MS 2000
`define SCC_MASTER_WAIT_CYC (`SCC_MASTER_WAIT_MS * (`SCC_CLK_HZ / 1000))
`endif

//--- shared/scc_pkg.sv
// types of the sensor command checker
package scc_pkg;
	typedef enum logic [1:0] {MFI_MASTER, MFI_TRIG, MFI_TEACH, MFI_OFF} scc_mfi_t;
	typedef enum logic [1:0] {KEY_MASTER, KEY_TEACH, KEY_OFF, KEY_RSVD} scc_key_t;
	typedef enum logic [1:0] {ST_RX, ST_CHECK, ST_WAIT} scc_state_t;
	typedef struct packed {
		logic warn;
		logic [9:0] code;
	} scc_reply_t;
	typedef struct packed {
		logic known;
		logic [3:0] pmin;
		logic [3:0] pmax;
		logic type_bad;
		logic range_bad;
		logic needs_stop;
		logic needs_expert;
		logic is_master;
		logic mv_oor;
		logic is_swtrig;
		logic is_roi;
		logic [8:0] roi_start;
		logic [8:0] roi_end;
		logic is_save_new;
		logic name_space;
		logic name_dup;
		logic load_missing;
		logic set_invalid;
		logic adapt_out;
		logic clamp_in;
	} scc_desc_t;
endpackage : scc_pkg

//--- hdl/scc_checker.sv
// command validation, error replies and input/key configuration
`timescale 1ns/1ps
`default_nettype none
`include "scc_consts.svh"
module scc_checker #(
	parameter int MASTER_WAIT_CYC = `SCC_MASTER_WAIT_CYC
) (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_byte_in,
	input wire scc_pkg::scc_desc_t desc_in,
	input wire logic tx_active_in,
	input wire logic meas_valid_in,
	input wire logic out_fail_in,
	input wire logic [3:0] upd_err_in,
	input wire logic laser_en_n_pin_in,
	input wire logic mfi_pin_in,
	input wire logic key_n_pin_in,
	input wire logic [2:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	output logic reply_valid_out,
	output scc_pkg::scc_reply_t reply_out,
	output logic exec_out,
	output logic busy_out,
	output logic laser_on_out,
	output logic mfi_master_out,
	output logic mfi_trig_out,
	output logic mfi_teach_out,
	output logic key_master_out,
	output logic key_teach_out
);
	scc_pkg::scc_state_t state_q;
	logic [2:0] arm_q;
	logic [8:0] len_q;
	logic over_q;
	logic bad_q;
	logic [3:0] tok_q;
	logic in_tok_q;
	logic [25:0] wait_q;
	logic [15:0] ctrl_q;
	logic [2:0] ssel_q;
	logic [15:0] setup_q [`SCC_SETUPS];
	logic [`SCC_SETUPS-1:0] svld_q;
	scc_pkg::scc_reply_t last_q;
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] prev_q;

	// byte classification
	wire is_cr = rx_byte_in == `SCC_CHR_CR;
	wire is_lf = rx_byte_in == `SCC_CHR_LF;
	wire is_sp = rx_byte_in == `SCC_CHR_SP;
	wire chr_ok = (rx_byte_in >= `SCC_CHR_LO) && (rx_byte_in <= `SCC_CHR_HI);
	wire take = ce_in && rx_valid_in && (state_q == scc_pkg::ST_RX);
	wire [3:0] pcnt = (tok_q == 4'h0) ? 4'h0 : tok_q - 4'h1;

	// configuration fields
	wire expert = ctrl_q[`SCC_CTRL_EXPERT];
	wire trig_sw = ctrl_q[`SCC_CTRL_TRIG_SW];
	wire mfi_high = ctrl_q[`SCC_CTRL_MFI_LVL];
	wire [1:0] mfi_bits = ctrl_q[`SCC_CTRL_MFI_HI:`SCC_CTRL_MFI_LO];
	wire [1:0] key_bits = ctrl_q[`SCC_CTRL_KEY_HI:`SCC_CTRL_KEY_LO];
	wire scc_pkg::scc_mfi_t mfi_func = scc_pkg::scc_mfi_t'(mfi_bits);
	wire scc_pkg::scc_key_t key_func = scc_pkg::scc_key_t'(key_bits);
	wire store_full = &svld_q;

	// error priority, first match wins
	wire e_roi = desc_in.is_roi && (desc_in.roi_start > desc_in.roi_end);
	wire e_pcnt = (pcnt < desc_in.pmin) || (pcnt > desc_in.pmax);
	wire e_stop = desc_in.needs_stop && tx_active_in;
	wire e_acc = desc_in.needs_expert && !expert;
	wire e_trig = desc_in.is_swtrig && !trig_sw;
	wire e_full = desc_in.is_save_new && store_full;
	wire [9:0] chk_code =
		over_q ? `SCC_E214 :
		bad_q ? `SCC_E204 :
		!desc_in.known ? `SCC_E210 :
		e_acc ? `SCC_E202 :
		e_stop ? `SCC_E262 :
		e_pcnt ? `SCC_E232 :
		desc_in.type_bad ? `SCC_E234 :
		desc_in.range_bad ? `SCC_E236 :
		e_roi ? `SCC_E600 :
		desc_in.mv_oor ? `SCC_E602 :
		e_trig ? `SCC_E616 :
		desc_in.name_space ? `SCC_E361 :
		desc_in.name_dup ? `SCC_E360 :
		e_full ? `SCC_E362 :
		desc_in.load_missing ? `SCC_E363 :
		desc_in.set_invalid ? `SCC_E364 :
		`SCC_E_OK;
	wire chk_err = chk_code != `SCC_E_OK;
	wire [9:0] warn_code =
		desc_in.adapt_out ? `SCC_W320 :
		desc_in.clamp_in ? `SCC_W570 :
		`SCC_E_OK;
	wire in_check = ce_in && (state_q == scc_pkg::ST_CHECK);
	wire in_wait = ce_in && (state_q == scc_pkg::ST_WAIT);
	wire wait_end = wait_q == 26'(MASTER_WAIT_CYC - 1);
	wire mv_got = in_wait && meas_valid_in;
	// a new command byte while mastering aborts it, unless meas_valid_in comes in the same cycle
	wire mv_abort = in_wait && !meas_valid_in && rx_valid_in;
	wire mv_tmo = in_wait && !meas_valid_in && !rx_valid_in && wait_end;
	wire go_now = in_check && !chk_err && !desc_in.is_master;
	wire go_wait = in_check && !chk_err && desc_in.is_master;
	wire [9:0] upd_code =
		upd_err_in[0] ? `SCC_E320 :
		upd_err_in[1] ? `SCC_E321 :
		upd_err_in[2] ? `SCC_E322 :
		`SCC_E323;
	wire cmd_rep = (in_check && (chk_err || !desc_in.is_master)) || mv_got || mv_abort || mv_tmo;
	wire side_rep = ce_in && !cmd_rep && (out_fail_in || (|upd_err_in));

	// reply selection
	wire [9:0] warn_sel = mv_got ? `SCC_E_OK : warn_code;
	wire [9:0] rep_code =
		(in_check && chk_err) ? chk_code :
		mv_abort ? `SCC_E220 :
		mv_tmo ? `SCC_E104 :
		(in_check || mv_got) ? warn_sel :
		out_fail_in ? `SCC_E200 :
		upd_code;
	wire rep_warn = (go_now || mv_got) && (warn_sel != `SCC_E_OK);

	// pin conditioning, sync2 onward is safe to use
	wire las_gnd = !sync2_q[0];
	wire mfi_act = mfi_high ? sync2_q[1] : !sync2_q[1];
	wire mfi_prev = mfi_high ? prev_q[1] : !prev_q[1];
	// edges count only once prev holds a real pin sample, else reset fakes a press
	wire mfi_rise = arm_q[2] && mfi_act && !mfi_prev;
	wire key_rise = arm_q[2] && !sync2_q[2] && prev_q[2];

	// register access
	wire wr_ctrl = ce_in && wr_in && (addr_in == `SCC_REG_CTRL);
	wire wr_ssel = ce_in && wr_in && (addr_in == `SCC_REG_SSEL);
	wire wr_sdat = ce_in && wr_in && (addr_in == `SCC_REG_SDAT);
	wire wr_svld = ce_in && wr_in && (addr_in == `SCC_REG_SVLD);
	wire [15:0] stat_w = {2'h0, (key_func == scc_pkg::KEY_OFF), laser_on_out,
		busy_out, last_q.warn, last_q.code};
	wire [15:0] rd_w =
		(addr_in == `SCC_REG_CTRL) ? ctrl_q :
		(addr_in == `SCC_REG_STAT) ? stat_w :
		(addr_in == `SCC_REG_SSEL) ? {13'h0000, ssel_q} :
		(addr_in == `SCC_REG_SDAT) ? setup_q[ssel_q] :
		(addr_in == `SCC_REG_SVLD) ? {8'h00, svld_q} :
		16'h0000;
	wire save_ok = go_now && desc_in.is_save_new;
	wire [2:0] free_idx;
	assign free_idx = !svld_q[0] ? 3'h0 : !svld_q[1] ? 3'h1 : !svld_q[2] ? 3'h2 :
		!svld_q[3] ? 3'h3 : !svld_q[4] ? 3'h4 : !svld_q[5] ? 3'h5 :
		!svld_q[6] ? 3'h6 : 3'h7;

	// receive path: length, charset and token count
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			len_q <= 9'h000;
			over_q <= 1'b0;
			bad_q <= 1'b0;
			tok_q <= 4'h0;
			in_tok_q <= 1'b0;
		end else if (in_check) begin
			len_q <= 9'h000;
			over_q <= 1'b0;
			bad_q <= 1'b0;
			tok_q <= 4'h0;
			in_tok_q <= 1'b0;
		end else if (take && !is_cr && !is_lf) begin
			if (len_q != 9'h1ff)
				len_q <= len_q + 9'h001;
			if (len_q >= `SCC_MAX_LEN)
				over_q <= 1'b1;
			if (!chr_ok)
				bad_q <= 1'b1;
			if (!is_sp && !in_tok_q && tok_q != 4'hf)
				tok_q <= tok_q + 4'h1;
			in_tok_q <= !is_sp;
		end
	end

	// command sequencing
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			state_q <= scc_pkg::ST_RX;
			wait_q <= 26'h0000000;
		end else if (ce_in) begin
			case (state_q)
			scc_pkg::ST_RX: begin
				if (rx_valid_in && is_cr)
					state_q <= scc_pkg::ST_CHECK;
			end
			scc_pkg::ST_CHECK: begin
				wait_q <= 26'h0000000;
				state_q <= go_wait ? scc_pkg::ST_WAIT : scc_pkg::ST_RX;
			end
			scc_pkg::ST_WAIT: begin
				wait_q <= wait_q + 26'h0000001;
				if (mv_got || mv_abort || mv_tmo)
					state_q <= scc_pkg::ST_RX;
			end
			default: state_q <= scc_pkg::ST_RX;
			endcase
		end
	end

	// replies and execute strobe
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			reply_valid_out <= 1'b0;
			reply_out <= '0;
			exec_out <= 1'b0;
			busy_out <= 1'b0;
			last_q <= '0;
		end else if (ce_in) begin
			reply_valid_out <= cmd_rep || side_rep;
			exec_out <= go_now || mv_got;
			busy_out <= go_wait || (in_wait && !(mv_got || mv_abort || mv_tmo));
			if (cmd_rep || side_rep) begin
				reply_out <= '{warn: rep_warn, code: rep_code};
				last_q <= '{warn: rep_warn, code: rep_code};
			end
		end
	end

	// registers and user setups
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			ctrl_q <= `SCC_CTRL_RST;
			ssel_q <= 3'h0;
			svld_q <= '0;
			rdata_out <= 16'h0000;
		end else if (ce_in) begin
			if (wr_ctrl)
				ctrl_q <= wdata_in;
			if (wr_ssel)
				ssel_q <= wdata_in[2:0];
			// a save in the same cycle as a software write still marks its setup
			if (wr_svld)
				svld_q <= wdata_in[7:0];
			if (wr_sdat)
				svld_q[ssel_q] <= 1'b1;
			if (save_ok)
				svld_q[free_idx] <= 1'b1;
			rdata_out <= rd_in ? rd_w : 16'h0000;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (ce_in && wr_sdat)
			setup_q[ssel_q] <= wdata_in;
	end

	// pins: laser enable, multifunction input, key
	always_ff @(posedge core_clk_in) begin
		if (!nrst_in) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
			prev_q <= 3'h7;
			arm_q <= 3'h0;
			laser_on_out <= 1'b0;
			mfi_master_out <= 1'b0;
			mfi_trig_out <= 1'b0;
			mfi_teach_out <= 1'b0;
			key_master_out <= 1'b0;
			key_teach_out <= 1'b0;
		end else if (ce_in) begin
			sync1_q <= {key_n_pin_in, mfi_pin_in, laser_en_n_pin_in};
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			arm_q <= {arm_q[1:0], 1'b1};
			laser_on_out <= las_gnd && ctrl_q[`SCC_CTRL_LASER];
			mfi_master_out <= mfi_rise && (mfi_func == scc_pkg::MFI_MASTER);
			mfi_trig_out <= mfi_act && (mfi_func == scc_pkg::MFI_TRIG);
			mfi_teach_out <= mfi_rise && (mfi_func == scc_pkg::MFI_TEACH);
			key_master_out <= key_rise && (key_func == scc_pkg::KEY_MASTER);
			key_teach_out <= key_rise && (key_func == scc_pkg::KEY_TEACH);
		end
	end

	// checks
	too_long_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		in_check && over_q |=> reply_valid_out && reply_out.code == `SCC_E214 && !exec_out)
		else $error("long command not refused");
	bad_char_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		in_check && !over_q && bad_q |=> reply_out.code == `SCC_E204)
		else $error("bad character not reported");
	unknown_cmd_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		in_check && !over_q && !bad_q && !desc_in.known
		|=> reply_out.code == `SCC_E210 && !exec_out ##1 !exec_out)
		else $error("unknown command executed");
	err_no_exec_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		reply_valid_out && !reply_out.warn && reply_out.code != `SCC_E_OK |-> !exec_out)
		else $error("error reply with execution");
	access_chk_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		reply_valid_out && reply_out.code == `SCC_E202 |-> !$past(expert))
		else $error("access refused with expert login");
	tx_busy_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		in_check && !over_q && !bad_q && desc_in.known && !e_acc && e_stop
		|=> reply_out.code == `SCC_E262 && !exec_out)
		else $error("command ran during transmission");
	roi_order_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		reply_valid_out && reply_out.code == `SCC_E600
		|-> $past(desc_in.roi_start) > $past(desc_in.roi_end))
		else $error("roi refused without reason");
	trig_mode_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		reply_valid_out && reply_out.code == `SCC_E616 |-> !$past(trig_sw))
		else $error("trigger refused in software mode");
	master_tmo_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		mv_tmo |=> reply_valid_out && reply_out.code == `SCC_E104 && !busy_out && !exec_out)
		else $error("mastering timeout not reported");
	laser_pin_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		ce_in && !las_gnd |=> !laser_on_out)
		else $error("laser on with enable pin open");
	key_lock_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		ce_in && key_func == scc_pkg::KEY_OFF |=> !key_master_out && !key_teach_out)
		else $error("locked key acted");
	param_cnt_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		in_check && !over_q && !bad_q && desc_in.known && !e_acc && !e_stop && e_pcnt
		|=> reply_valid_out && reply_out.code == `SCC_E232 && !exec_out)
		else $error("parameter count not refused");
	range_err_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		reply_valid_out && reply_out.code == `SCC_E236 |-> $past(desc_in.range_bad))
		else $error("range error without cause");
	master_range_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		reply_valid_out && reply_out.code == `SCC_E602 |-> $past(desc_in.mv_oor))
		else $error("master range error without cause");
	name_space_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		reply_valid_out && reply_out.code == `SCC_E361 |-> $past(desc_in.name_space))
		else $error("name error without cause");
	store_full_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		reply_valid_out && reply_out.code == `SCC_E362 |-> &$past(svld_q))
		else $error("storage full reported with room left");
	out_fail_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		ce_in && out_fail_in && !cmd_rep
		|=> reply_valid_out && reply_out.code == `SCC_E200 && !reply_out.warn)
		else $error("output failure not reported");
	upd_hdr_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		ce_in && upd_err_in[0] && !out_fail_in && !cmd_rep
		|=> reply_valid_out && reply_out.code == `SCC_E320 && !reply_out.warn)
		else $error("update header fault not reported");
	warn_exec_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		reply_valid_out && reply_out.warn |-> exec_out)
		else $error("warning without execution");
	master_abort_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		mv_abort |=> reply_valid_out && reply_out.code == `SCC_E220 && !exec_out)
		else $error("mastering abort not reported");
	master_done_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		mv_got |=> reply_valid_out && exec_out && !busy_out)
		else $error("mastering value not taken");
	setup_keep_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		ce_in && !wr_svld |=> (svld_q & $past(svld_q)) == $past(svld_q))
		else $error("setup lost without write");
	mfi_off_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		ce_in && mfi_func == scc_pkg::MFI_OFF
		|=> !mfi_master_out && !mfi_trig_out && !mfi_teach_out)
		else $error("inactive input acted");
	pin_arm_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		ce_in && !arm_q[2]
		|=> !mfi_master_out && !mfi_teach_out && !key_master_out && !key_teach_out)
		else $error("pin edge taken before sync filled");
endmodule : scc_checker
`default_nettype wire

//--- testbench/scc_host_model.sv
// host model: sends ascii command lines and runs measurement transmission
`timescale 1ns/1ps
`default_nettype none
`include "scc_consts.svh"
module scc_host_model (
	input wire logic core_clk_in,
	output logic rx_valid_out,
	output logic [7:0] rx_byte_out,
	output logic tx_active_out
);
	initial begin
		rx_valid_out = 1'b0;
		rx_byte_out = 8'h00;
		tx_active_out = 1'b0;
	end
	task automatic put(input logic [7:0] b);
		@(posedge core_clk_in);
		rx_valid_out <= 1'b1;
		rx_byte_out <= b;
	endtask : put
	// a released byte line shows the inverse so a stale value is never mistaken for data
	task automatic idle();
		@(posedge core_clk_in);
		rx_valid_out <= 1'b0;
		rx_byte_out <= ~rx_byte_out;
	endtask : idle
	task automatic send(input int n, input logic [7:0] ch, input string s);
		for (int i = 0; i < n; i++) put(ch);
		for (int i = 0; i < s.len(); i++) put(s[i]);
		put(`SCC_CHR_CR);
		idle();
	endtask : send
	// the test turns transmission on or off; the host does not stop it before commands that need it stopped
	task automatic set_tx(input logic on);
		@(posedge core_clk_in);
		tx_active_out <= on;
	endtask : set_tx
endmodule : scc_host_model
`default_nettype wire

//--- testbench/test_sensor_command_error_checker.sv
// self-checking bench of the sensor command checker
`timescale 1ns/1ps
`default_nettype none
`include "scc_consts.svh"
module test_sensor_command_error_checker;
	logic core_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic meas_valid_in = 1'b0;
	logic out_fail_in = 1'b0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic laser_en_n_pin_in = 1'b1;
	logic mfi_pin_in = 1'b0;
	logic key_n_pin_in = 1'b1;
	logic [3:0] upd_err_in = 4'h0;
	logic [2:0] addr_in = 3'h0;
	logic [15:0] wdata_in = 16'h0000;
	scc_pkg::scc_desc_t desc_in = '0;
	wire logic rx_valid, tx_active, reply_valid_out, exec_out, busy_out, laser_on_out;
	wire logic mfi_master_out, mfi_trig_out, mfi_teach_out, key_master_out, key_teach_out;
	wire logic [7:0] rx_byte;
	wire logic [15:0] rdata_out;
	wire scc_pkg::scc_reply_t reply_out;
	int miscompares = 0;
	int checks = 0;
	always #20 core_clk_in = ~core_clk_in;
	scc_host_model scc_host_model_inst (.core_clk_in(core_clk_in), .rx_valid_out(rx_valid),
		.rx_byte_out(rx_byte), .tx_active_out(tx_active));
	// short mastering wait keeps the timeout case quick
	scc_checker #(.MASTER_WAIT_CYC(20)) scc_checker_inst (.core_clk_in(core_clk_in),
		.nrst_in(nrst_in), .ce_in(1'b1), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte),
		.desc_in(desc_in), .tx_active_in(tx_active), .meas_valid_in(meas_valid_in),
		.out_fail_in(out_fail_in), .upd_err_in(upd_err_in),
		.laser_en_n_pin_in(laser_en_n_pin_in), .mfi_pin_in(mfi_pin_in),
		.key_n_pin_in(key_n_pin_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out), .reply_valid_out(reply_valid_out),
		.reply_out(reply_out), .exec_out(exec_out), .busy_out(busy_out),
		.laser_on_out(laser_on_out), .mfi_master_out(mfi_master_out),
		.mfi_trig_out(mfi_trig_out), .mfi_teach_out(mfi_teach_out),
		.key_master_out(key_master_out), .key_teach_out(key_teach_out));
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge core_clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge core_clk_in);
		rd_in <= 1'b0;
		@(negedge core_clk_in);
		d = rdata_out;
	endtask : rd
	task automatic rsp(input logic w, input logic [9:0] c, input logic ex);
		logic [11:0] r;
		r = 12'hfff;
		for (int i = 0; i < 40; i++) begin
			@(negedge core_clk_in);
			if (reply_valid_out === 1'b1) begin
				r = {reply_out, exec_out};
				break;
			end
		end
		chk("reply", {4'h0, r}, {4'h0, w, c, ex});
	endtask : rsp
	task automatic cmd(input scc_pkg::scc_desc_t d, input int n, input logic [7:0] ch,
		input string s);
		@(posedge core_clk_in);
		desc_in <= d;
		scc_host_model_inst.send(n, ch, s);
	endtask : cmd
	task automatic wait_busy();
		for (int i = 0; i < 10; i++) begin
			@(negedge core_clk_in);
			if (busy_out === 1'b1) break;
		end
		chk("busy", {15'h0, busy_out}, 16'h0001);
	endtask : wait_busy
	function automatic scc_pkg::scc_desc_t base();
		scc_pkg::scc_desc_t d;
		d = '0;
		d.known = 1'b1;
		d.pmin = 4'h1;
		d.pmax = 4'h1;
		return d;
	endfunction : base
	task automatic t_regs();
		logic [15:0] v;
		rd(3'h0, v);
		chk("ctrl", v, `SCC_CTRL_RST);
		rd(3'h4, v);
		chk("valid", v, 16'h0000);
		wr(3'h5, 16'hffff);
		rd(3'h5, v);
		chk("unmapped", v, 16'h0000);
	endtask : t_regs
	task automatic t_errors();
		scc_pkg::scc_desc_t d;
		logic [9:0] c [0:18];
		logic w;
		c = '{`SCC_E_OK, `SCC_E210, `SCC_E202, `SCC_E262, `SCC_E232, `SCC_E234, `SCC_E236,
			`SCC_E600, `SCC_E602, `SCC_E616, `SCC_E361, `SCC_E360, `SCC_E363, `SCC_E364,
			`SCC_W320, `SCC_W570, `SCC_E_OK, `SCC_E_OK, `SCC_E_OK};
		for (int i = 0; i < 19; i++) begin
			d = base();
			case (i)
				1: d.known = 1'b0;
				2, 17: d.needs_expert = 1'b1;
				3, 16: d.needs_stop = 1'b1;
				4: d.pmin = 4'h2;
				5: d.type_bad = 1'b1;
				6: d.range_bad = 1'b1;
				7: {d.is_roi, d.roi_start, d.roi_end} = {1'b1, 9'h101, 9'h100};
				8: {d.is_master, d.mv_oor} = 2'h3;
				9, 18: d.is_swtrig = 1'b1;
				10: d.name_space = 1'b1;
				11: d.name_dup = 1'b1;
				12: d.load_missing = 1'b1;
				13: d.set_invalid = 1'b1;
				14: d.adapt_out = 1'b1;
				15: d.clamp_in = 1'b1;
				default: ;
			endcase
			wr(3'h0, (i == 17) ? 16'h0040 : ((i == 18) ? 16'h0080 : 16'h0000));
			scc_host_model_inst.set_tx(i == 3);
			w = (i == 14 || i == 15);
			cmd(d, 0, 8'h41, "A B");
			rsp(w, c[i], w || c[i] == 10'h000);
		end
		scc_host_model_inst.set_tx(1'b0);
		wr(3'h0, 16'h0000);
	endtask : t_errors
	task automatic t_length();
		scc_pkg::scc_desc_t d;
		d = base();
		d.pmin = 4'h0;
		d.pmax = 4'h0;
		cmd(d, 255, 8'h41, "");
		rsp(1'b0, `SCC_E_OK, 1'b1);
		cmd(d, 256, 8'h41, "");
		rsp(1'b0, `SCC_E214, 1'b0);
		cmd(d, 1, 8'h7f, "");
		rsp(1'b0, `SCC_E204, 1'b0);
	endtask : t_length
	task automatic t_setups();
		scc_pkg::scc_desc_t d;
		logic [15:0] v;
		d = base();
		d.is_save_new = 1'b1;
		for (int i = 0; i < 9; i++) begin
			cmd(d, 0, 8'h41, "A B");
			rsp(1'b0, (i < `SCC_SETUPS) ? `SCC_E_OK : `SCC_E362, i < `SCC_SETUPS);
		end
		rd(3'h4, v);
		chk("valid", v, 16'h00ff);
	endtask : t_setups
	task automatic t_master();
		scc_pkg::scc_desc_t d;
		logic [15:0] v;
		d = base();
		d.is_master = 1'b1;
		cmd(d, 0, 8'h41, "A B");
		wait_busy();
		@(posedge core_clk_in);
		meas_valid_in <= 1'b1;
		@(posedge core_clk_in);
		meas_valid_in <= 1'b0;
		rsp(1'b0, `SCC_E_OK, 1'b1);
		cmd(d, 0, 8'h41, "A B");
		wait_busy();
		rsp(1'b0, `SCC_E104, 1'b0);
		rd(3'h1, v);
		chk("status", v & 16'h0fff, 16'h0000 | `SCC_E104);
		cmd(d, 0, 8'h41, "A B");
		wait_busy();
		scc_host_model_inst.put(8'h41);
		scc_host_model_inst.idle();
		rsp(1'b0, `SCC_E220, 1'b0);
	endtask : t_master
	task automatic t_side();
		logic [9:0] c [0:3];
		c = '{`SCC_E320, `SCC_E321, `SCC_E322, `SCC_E323};
		@(posedge core_clk_in);
		out_fail_in <= 1'b1;
		@(posedge core_clk_in);
		out_fail_in <= 1'b0;
		rsp(1'b0, `SCC_E200, 1'b0);
		for (int b = 0; b < 4; b++) begin
			@(posedge core_clk_in);
			upd_err_in <= 4'h1 << b;
			@(posedge core_clk_in);
			upd_err_in <= 4'h0;
			rsp(1'b0, c[b], 1'b0);
		end
	endtask : t_side
	task automatic t_laser();
		wr(3'h0, 16'h0001);
		repeat (5) @(negedge core_clk_in);
		chk("laser open", {15'h0, laser_on_out}, 16'h0000);
		@(posedge core_clk_in);
		laser_en_n_pin_in <= 1'b0;
		repeat (5) @(negedge core_clk_in);
		chk("laser gnd", {15'h0, laser_on_out}, 16'h0001);
		wr(3'h0, 16'h0000);
		repeat (3) @(negedge core_clk_in);
		chk("laser off", {15'h0, laser_on_out}, 16'h0000);
	endtask : t_laser
	// pins are set idle before the config write; only outputs after the later press are counted
	task automatic pin_case(input logic [15:0] ctrl, input logic idle, input logic [4:0] exp);
		logic [4:0] seen;
		@(posedge core_clk_in);
		mfi_pin_in <= idle;
		key_n_pin_in <= 1'b1;
		repeat (6) @(posedge core_clk_in);
		wr(3'h0, ctrl);
		repeat (6) @(posedge core_clk_in);
		mfi_pin_in <= ~idle;
		key_n_pin_in <= 1'b0;
		seen = 5'h00;
		repeat (8) begin
			@(negedge core_clk_in);
			seen |= {mfi_master_out, mfi_trig_out, mfi_teach_out, key_master_out, key_teach_out};
		end
		chk("pins", {11'h0, seen}, {11'h0, exp});
	endtask : pin_case
	initial begin
		repeat (3) @(posedge core_clk_in);
		nrst_in <= 1'b1;
		t_regs();
		t_errors();
		t_length();
		t_setups();
		t_master();
		t_side();
		t_laser();
		pin_case(16'h0028, 1'b0, 5'b10000);
		pin_case(16'h0022, 1'b1, 5'b01000);
		pin_case(16'h002c, 1'b0, 5'b00100);
		pin_case(16'h002e, 1'b0, 5'b00000);
		pin_case(16'h000e, 1'b0, 5'b00010);
		pin_case(16'h001e, 1'b0, 5'b00001);
		pin_case(16'h003e, 1'b0, 5'b00000);
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge core_clk_in);
		miscompares++;
		complete_run();
	end
endmodule : test_sensor_command_error_checker
`default_nettype wire
